// ===== hdl/dcc_pkg.sv
// Package: register map, field positions and constants of the comparator control
package dcc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [3:0]  DCC_ADDR_W          = 4'h4;   // Address width
  localparam logic [3:0]  DCC_OFS_CONTROL     = 4'h0;   // comparator_control
  localparam logic [3:0]  DCC_OFS_OUT_ENABLE  = 4'h4;   // Pin output enables
  localparam logic [15:0] DCC_CONTROL_RESET   = 16'h0000;
  localparam logic [1:0]  DCC_OUT_EN_RESET    = 2'h0;

  // ==========================================================================
  // Field positions in comparator_control
  // ==========================================================================
  localparam int DCC_BIT_CMP1_POS    = 0;
  localparam int DCC_BIT_CMP1_NEG    = 1;
  localparam int DCC_BIT_CMP2_POS    = 2;
  localparam int DCC_BIT_CMP2_NEG    = 3;
  localparam int DCC_BIT_CMP1_INV    = 4;
  localparam int DCC_BIT_CMP2_INV    = 5;
  localparam int DCC_BIT_CMP1_RESULT = 6;
  localparam int DCC_BIT_CMP2_RESULT = 7;
  localparam logic [15:0] DCC_CONTROL_WMASK = 16'h003F; // Writable bits

  // Field positions in the output enable register
  localparam int DCC_BIT_CMP1_OUTEN  = 0;
  localparam int DCC_BIT_CMP2_OUTEN  = 1;

  // ==========================================================================
  // AXI4-Lite responses
  // ==========================================================================
  localparam logic [1:0] DCC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;

  // Synchroniser depth
  localparam int DCC_SYNC_STAGES = 2;

endpackage

// ===== hdl/dcc_sync_if.sv
// Interface: raw comparator levels in, synchronised levels out
`timescale 1ns/1ns
interface dcc_sync_if;
  logic [1:0] raw;      // Asynchronous comparator outputs
  logic [1:0] synced;   // Levels on core_clk
  modport top  (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// ===== hdl/dcc_sync.sv
// Module: two-flop synchroniser for the comparator outputs
`timescale 1ns/1ns
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Level carrier
  dcc_sync_if.sync  sif
);
  import dcc_pkg::*;

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (WIDTH != 2)
  begin : g_bad
    $error("dcc_sync serves exactly two comparators");
  end

  logic [WIDTH-1:0] meta_r;   // First stage, read only by the second
  logic [WIDTH-1:0] sync_r;   // Second stage

  // ==========================================================================
  // Two flops per bit; the first stage feeds nothing else
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= sif.raw;   // RULE_10
      sync_r <= meta_r;    // RULE_10
    end
  end

  assign sif.synced = sync_r;

endmodule

// ===== hdl/dcc_top.sv
// Module: dual comparator control register bank with AXI4-Lite slave
//
// Overview of operation
// RULE_01: Bit 6 reads comparator 1 result, inversion-aware.
// RULE_02: Bit 5 inverts comparator 2 output.
// RULE_03: Bit 4 inverts comparator 1 output and status.
// RULE_04: Bit 3 picks comparator 2 negative input.
// RULE_05: Bit 2 picks comparator 2 positive input.
// RULE_06: Bit 1 picks comparator 1 negative input.
// RULE_07: Bit 0 picks comparator 1 positive input.
// RULE_08: Software maps enabled comparator 2 to pin.
// RULE_09: Software maps enabled comparator 1 to pin.
// RULE_10: Synchronise comparator outputs before inversion and status.
`timescale 1ns/1ns
module dcc_top
  import dcc_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // AXI4-Lite write address
  input  wire logic [DCC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [DCC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Analog comparator cores
  input  wire logic                  cmp1_raw,
  input  wire logic                  cmp2_raw,
  output logic                       cmp1_pos_select,
  output logic                       cmp1_neg_select,
  output logic                       cmp2_pos_select,
  output logic                       cmp2_neg_select,
  // Towards the pin-remapping fabric
  output logic                       cmp1_out,
  output logic                       cmp2_out,
  output logic                       cmp1_pin_out_enable,
  output logic                       cmp2_pin_out_enable
);
  import dcc_pkg::*;

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Result bits 6 and 7 are never stored; they are read live
  logic [15:0] control_r;       // Writable part of comparator_control
  logic [1:0]  out_en_r;        // Pin output enables
  logic        cmp1_result_r;   // Inversion-aware comparator 1 result
  logic        cmp2_result_r;   // Inversion-aware comparator 2 result

  // Write channel capture
  logic                  aw_held_r;   // Address taken, waiting for data
  logic [DCC_ADDR_W-1:0] aw_addr_r;   // Held write address
  logic                  w_held_r;    // Data taken, waiting for address
  logic [31:0]           w_data_r;    // Held write data
  logic [3:0]            w_strb_r;    // Held byte strobes

  // Synchroniser carrier
  dcc_sync_if sif ();

  // ==========================================================================
  // Comparator output synchroniser
  // ==========================================================================
  // The comparators run free of core_clk, so a raw level may be caught
  // mid-swing; two flops give a metastable sample time to settle
  assign sif.raw = {cmp2_raw, cmp1_raw};

  dcc_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .sif      (sif)
  );

  // ==========================================================================
  // Result with polarity applied, registered so outputs come from flops
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp1_result_r <= 1'b0;
      cmp2_result_r <= 1'b0;
    end
    else
    begin
      // Inversion sits after the synchroniser, so a flip is glitch free
      // Costs one cycle more than a plain xor, but outputs stay on flops
      cmp1_result_r <= sif.synced[0] ^ control_r[DCC_BIT_CMP1_INV]; // RULE_03
      cmp2_result_r <= sif.synced[1] ^ control_r[DCC_BIT_CMP2_INV]; // RULE_02
    end
  end

  // ==========================================================================
  // Write path: address and data accepted in either order
  // ==========================================================================
  logic do_write;                    // Both halves present, response free
  logic [DCC_ADDR_W-1:0] wr_addr;    // Effective write address
  logic [31:0]           wr_data;    // Effective write data
  logic [3:0]            wr_strb;    // Effective strobes

  always_comb
  begin
    // A held half wins over the live bus, since the master is free to
    // release a half as soon as it has been taken
    wr_addr  = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wr_data  = w_held_r  ? w_data_r  : s_axi_wdata;
    wr_strb  = w_held_r  ? w_strb_r  : s_axi_wstrb;
    do_write = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
               (w_held_r  || (s_axi_wvalid  && s_axi_wready)) &&
               !s_axi_bvalid;
  end

  // Channel readiness; each ready drops once its half is held
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= '0;
      w_strb_r      <= '0;
    end
    else
    begin
      if (do_write)
      begin
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        // Ready only while idle on that half and no response pending
        s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) &&
                         !s_axi_bvalid;
        s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) &&
                         !s_axi_bvalid;
      end
    end
  end

  // Write response
  // It stands until bready; no further write is taken before then
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DCC_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      // Unmapped addresses answer with a slave error
      if (wr_addr == DCC_OFS_CONTROL || wr_addr == DCC_OFS_OUT_ENABLE)
        s_axi_bresp <= DCC_RESP_OKAY;
      else
        s_axi_bresp <= DCC_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Register writes; only byte lane 0 holds implemented bits
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_r <= DCC_CONTROL_RESET;
      out_en_r  <= DCC_OUT_EN_RESET;
    end
    // Upper byte lanes carry nothing, so their strobes are ignored
    else if (do_write && wr_strb[0])
    begin
      if (wr_addr == DCC_OFS_CONTROL)
        // Status bits are read only and never stored
        control_r <= wr_data[15:0] & DCC_CONTROL_WMASK; // RULE_02 RULE_03
      else if (wr_addr == DCC_OFS_OUT_ENABLE)
        out_en_r  <= wr_data[1:0];
    end
  end

  // ==========================================================================
  // Read path: one word per request, answered the next cycle
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= DCC_RESP_OKAY;
    end
    else
    begin
      // arready rests low while a response is pending, so the single
      // read data register is never overwritten before it is taken
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= DCC_RESP_OKAY;
        s_axi_rdata   <= '0;
        case (s_axi_araddr)
          DCC_OFS_CONTROL:
          begin
            s_axi_rdata[15:0] <= control_r;
            s_axi_rdata[DCC_BIT_CMP1_RESULT] <= cmp1_result_r; // RULE_01
            s_axi_rdata[DCC_BIT_CMP2_RESULT] <= cmp2_result_r;
          end
          DCC_OFS_OUT_ENABLE:
            s_axi_rdata[1:0] <= out_en_r;
          // Unmapped offsets answer with zero data
          default:
            s_axi_rresp <= DCC_RESP_SLVERR;
        endcase
      end
      else if (s_axi_rvalid)
      begin
        if (s_axi_rready)
          s_axi_rvalid <= 1'b0;
      end
      else
      begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Selector and fabric outputs, all from flops
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp1_pos_select     <= 1'b0;
      cmp1_neg_select     <= 1'b0;
      cmp2_pos_select     <= 1'b0;
      cmp2_neg_select     <= 1'b0;
      cmp1_out            <= 1'b0;
      cmp2_out            <= 1'b0;
      cmp1_pin_out_enable <= 1'b0;
      cmp2_pin_out_enable <= 1'b0;
    end
    else
    begin
      // Each output leaves through a flop, so the analog selectors move
      // one cycle after the register write has landed
      // 1 = VIN+ pin, 0 = internal_voltage_reference
      cmp1_pos_select <= control_r[DCC_BIT_CMP1_POS]; // RULE_07
      // 1 = VIN+ pin, 0 = VIN- pin
      cmp1_neg_select <= control_r[DCC_BIT_CMP1_NEG]; // RULE_06
      cmp2_pos_select <= control_r[DCC_BIT_CMP2_POS]; // RULE_05
      cmp2_neg_select <= control_r[DCC_BIT_CMP2_NEG]; // RULE_04
      cmp1_out        <= cmp1_result_r;
      cmp2_out        <= cmp2_result_r;
      // Software must still route these through a remappable_pin
      cmp1_pin_out_enable <= out_en_r[DCC_BIT_CMP1_OUTEN]; // RULE_09
      cmp2_pin_out_enable <= out_en_r[DCC_BIT_CMP2_OUTEN]; // RULE_08
    end
  end

endmodule

// ===== verification/dcc_chk.sv
// Checker: bus handshake and comparator path properties of dcc_top
`timescale 1ns/1ns
module dcc_chk
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Comparator side
  input wire logic        cmp1_raw,
  input wire logic        cmp2_raw,
  input wire logic        cmp1_out,
  input wire logic        cmp2_out,
  input wire logic        cmp1_pos_select,
  input wire logic        cmp1_neg_select,
  input wire logic        cmp2_pos_select,
  input wire logic        cmp2_neg_select,
  input wire logic        cmp1_pin_out_enable,
  input wire logic        cmp2_pin_out_enable
);
  // ==========
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Completed handshakes
  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_b_take; s_axi_bvalid && s_axi_bready; endsequence
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_unused: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
    && (s_axi_rresp == DCC_RESP_OKAY || s_axi_rdata == 32'h0))
    else $error("rdata upper bits set");
  a_aw_return: assert property (s_b_take |-> ##[1:2] s_axi_awready)
    else $error("awready not back");
  a_sel_cause: assert property (
    $changed({cmp2_neg_select, cmp2_pos_select, cmp1_neg_select,
    cmp1_pos_select}) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("select moved");
  a_en_cause: assert property ($changed({cmp2_pin_out_enable,
    cmp1_pin_out_enable}) |-> $past(s_axi_bvalid) &&
    !$past(s_axi_bvalid, 2)) else $error("en moved");
  a_sync_one: assert property ($changed(cmp1_out) |->
    $past(cmp1_raw, 4) != $past(cmp1_raw, 5) || $past(s_axi_bvalid)
    || $past(s_axi_bvalid, 2)) else $error("cmp1_out moved early");
  a_sync_two: assert property ($changed(cmp2_out) |->
    $past(cmp2_raw, 4) != $past(cmp2_raw, 5) || $past(s_axi_bvalid)
    || $past(s_axi_bvalid, 2)) else $error("cmp2_out moved early");
endmodule

bind dcc_top dcc_chk chk_u (.core_clk, .rst_n, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp1_raw, .cmp2_raw, .cmp1_out,
  .cmp2_out, .cmp1_pos_select, .cmp1_neg_select, .cmp2_pos_select,
  .cmp2_neg_select, .cmp1_pin_out_enable, .cmp2_pin_out_enable);

// ===== verification/dcc_top_tb.sv
// Testbench: self-checking bench for the comparator control bank
`timescale 1ns/1ns
module dcc_top_tb;
  import dcc_pkg::*;
  // Design inputs, all defined at time zero
  logic                  core_clk = 1'h0;
  logic                  rst_n = 1'h0;
  logic [DCC_ADDR_W-1:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0]            s_axi_wstrb = 4'h0;
  logic [31:0]           s_axi_wdata = 32'h0;
  logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic                  s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic                  s_axi_arvalid = 1'h0;
  logic                  cmp1_raw = 1'h0, cmp2_raw = 1'h0;
  // Design outputs
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                  s_axi_arready, s_axi_rvalid;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [31:0]           s_axi_rdata;
  logic                  cmp1_pos_select, cmp1_neg_select, cmp1_out;
  logic                  cmp2_pos_select, cmp2_neg_select, cmp2_out;
  logic                  cmp1_pin_out_enable, cmp2_pin_out_enable;
  // Grouped views of the outputs
  wire [3:0] sel = {cmp2_neg_select, cmp2_pos_select, cmp1_neg_select,
                    cmp1_pos_select};
  wire [1:0] outs = {cmp2_out, cmp1_out};
  wire [1:0] ens  = {cmp2_pin_out_enable, cmp1_pin_out_enable};
  int        err_total = 0, comparisons = 0, cycles = 0;

  dcc_top dut_u (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmp1_raw, .cmp2_raw, .cmp1_pos_select, .cmp1_neg_select,
    .cmp2_pos_select, .cmp2_neg_select, .cmp1_out, .cmp2_out,
    .cmp1_pin_out_enable, .cmp2_pin_out_enable);

  // ==========
  // Clock and hang guard; the run needs a few hundred cycles at most
  initial
    forever #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      final_report();
    end
  end

  // ==========
  // Verdict and comparison
  task automatic final_report();
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Expected pin levels and control readback
  function automatic logic [1:0] exp_out(logic [5:0] c, logic [1:0] v);
    return {v[1] ^ c[5], v[0] ^ c[4]};
  endfunction
  function automatic logic [31:0] exp_ctl(logic [5:0] c, logic [1:0] v);
    return {24'h0, exp_out(c, v), c};
  endfunction

  // ==========
  // Bus master; response ready comes late at random to stall the slave
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge core_clk);
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    while (!(ad && wd));
    repeat ($urandom % 3) @(posedge core_clk);
    s_axi_bready <= 1'h1;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge core_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    repeat ($urandom % 3) @(posedge core_clk);
    s_axi_rready <= 1'h1;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // ==========
  // Main sequence
  initial
  begin
    logic [1:0]  r, o, n, e;
    logic [31:0] d;
    logic [5:0]  c;
    void'($urandom(29951));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    axi_rd(DCC_OFS_CONTROL, d, r);
    chk("ctl_reset", {16'h0, DCC_CONTROL_RESET}, d);
    axi_rd(DCC_OFS_OUT_ENABLE, d, r);
    chk("en_reset", {30'h0, DCC_OUT_EN_RESET}, d);
    for (int i = 0; i < 16; i++)
    begin
      // First two passes are the all-set and all-clear corners
      c = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : 6'($urandom);
      axi_wr(DCC_OFS_CONTROL, {26'($urandom), c}, {3'($urandom), 1'h1}, r);
      chk("bresp", 32'(DCC_RESP_OKAY), 32'(r));
      o = {cmp2_raw, cmp1_raw};
      n = 2'($urandom);
      // Selects leave their flop one edge after the write lands
      @(posedge core_clk);
      chk("select", 32'(c[3:0]), 32'(sel));
      cmp1_raw <= n[0];
      cmp2_raw <= n[1];
      // A level launched at one edge is looked at on the next
      repeat (4) @(posedge core_clk);
      chk("out_old", 32'(exp_out(c, o)), 32'(outs));
      @(posedge core_clk);
      chk("out_new", 32'(exp_out(c, n)), 32'(outs));
      axi_rd(DCC_OFS_CONTROL, d, r);
      chk("ctl_read", exp_ctl(c, n), d);
      chk("rd_resp", 32'(DCC_RESP_OKAY), 32'(r));
      e = 2'($urandom);
      axi_wr(DCC_OFS_OUT_ENABLE, {30'($urandom), e}, 4'h1, r);
      chk("en_bresp", 32'(DCC_RESP_OKAY), 32'(r));
      @(posedge core_clk);
      chk("pin_en", 32'(e), 32'(ens));
      axi_rd(DCC_OFS_OUT_ENABLE, d, r);
      chk("en_read", 32'(e), d);
    end
    // Write with byte 0 disabled leaves the register alone
    axi_wr(DCC_OFS_CONTROL, {26'h0, ~c}, 4'hE, r);
    chk("strb_resp", 32'(DCC_RESP_OKAY), 32'(r));
    // Unmapped write and read are refused
    axi_wr(4'h8, 32'hFFFFFFFF, 4'hF, r);
    chk("bad_wresp", 32'(DCC_RESP_SLVERR), 32'(r));
    axi_rd(DCC_OFS_CONTROL, d, r);
    chk("ctl_kept", exp_ctl(c, n), d);
    chk("en_kept", 32'(e), 32'(ens));
    axi_rd(4'hC, d, r);
    chk("bad_rresp", 32'(DCC_RESP_SLVERR), 32'(r));
    chk("bad_rdata", 32'h0, d);
    final_report();
  end
endmodule
